// >>> bench/cise_core_tb.sv
/*
 * Self-checking bench of the execution core: runs a short program.
 * Assumes the program memory model beside it and the core's hand-over timing.
 */
module cise_core_tb;
    timeunit 1ns;
    timeprecision 1ns;
    // ============================================================
    // Signals
    localparam logic [8:0] HEAD = 9'h040; // Return address on the stack
    logic clk_i = 1'b0; // Bench clock
    logic rd_q = 1'b0; // Read issued last cycle
    logic rst_n_i, pop, pin, wr, rd, zf, ton, pdn, pwf, slp, osc, load;
    logic [8:0] pc, head, ld_addr;
    logic [11:0] instr, ld_data;
    logic [3:0] addr;
    logic [7:0] wdata, rdata, acc, pre, k, r;
    logic [11:0] prog [12]; // Program words
    logic [7:0] ea [12]; // Accumulator after each step
    logic ez [12]; // Zero flag after each step
    logic [7:0] exp_q [$]; // Expected read data
    int n_fail = 0;
    int n_checks = 0;
    int cyc = 0;
    // Clock, 40 ns period
    always #20 clk_i = ~clk_i;
    cise_core i_cise_core (.clk_i(clk_i), .rst_n_i(rst_n_i), .pc_o(pc), .instr_i(instr),
        .stack_head_entry_i(head), .stack_pop_o(pop), .pin_change_i(pin), .addr_i(addr),
        .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .accum_o(acc),
        .prescale_cfg_o(pre), .zero_flag_o(zf), .expiry_flag_n_o(ton),
        .power_off_flag_n_o(pdn), .pin_change_wake_flag_o(pwf), .sleeping_o(slp),
        .osc_run_o(osc));
    cise_prog_mem #(.RET_ADDR(HEAD)) i_cise_prog_mem (.clk_i(clk_i), .pc_i(pc),
        .instr_o(instr), .stack_pop_i(pop), .stack_head_o(head), .load_i(load),
        .load_addr_i(ld_addr), .load_data_i(ld_data));
    // ============================================================
    // Tasks
    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string msg);
        n_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("CHECK FAILED t=%0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask : check
    task close_out;
        $display("checks %0d failures %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : close_out
    task wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_i);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk_i);
        wr <= 1'b0;
    endtask : wr_reg
    task rd_reg(input logic [3:0] a, input logic [7:0] e);
        @(posedge clk_i);
        rd <= 1'b1;
        addr <= a;
        exp_q.push_back(e);
        @(posedge clk_i);
        rd <= 1'b0;
    endtask : rd_reg
    task step;
        @(posedge clk_i);
        #1;
    endtask : step
    // Read data checker and timeout
    always @(posedge clk_i)
    begin
        if (rd_q)
            check(rdata, exp_q.pop_front(), "read data");
        rd_q <= rd;
        cyc++;
        if (cyc > 2000)
        begin
            n_fail++;
            close_out();
        end
    end
    // ============================================================
    // Main sequence
    initial
    begin
        rst_n_i = 1'b0;
        {pin, wr, rd, load, addr, wdata, ld_addr, ld_data} = '0;
        void'($urandom(35962));
        k = 8'($urandom_range(255, 1));
        r = 8'($urandom_range(255, 0));
        prog = '{12'hc00, 12'h025, 12'h225, {4'hc, k}, 12'h023, 12'h002, 12'h000, 12'h125,
            12'hc00, 12'h103, 12'h205, {4'h8, r}};
        ea = '{8'h00, 8'h00, 8'h00, k, k, k, k, k, 8'h00, k, k, r};
        ez = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
        repeat (3) @(posedge clk_i);
        rst_n_i <= 1'b1;
        // Program load, sleep word at the return address
        for (int i = 0; i < 13; i++)
        begin
            @(posedge clk_i);
            load <= 1'b1;
            ld_addr <= (i < 12) ? 9'(i) : HEAD;
            ld_data <= (i < 12) ? prog[i] : 12'h003;
        end
        @(posedge clk_i);
        load <= 1'b0;
        // Reset values and an unmapped read
        rd_reg(4'h1, 8'h06);
        rd_reg(4'h2, 8'h00);
        rd_reg(4'h3, 8'h00);
        rd_reg(4'h5, 8'h00);
        rd_reg(4'hf, 8'h00);
        $display("test reset values done");
        // Pin pulse, then idle so the watchdog prescaler wraps
        pin <= 1'b1;
        repeat (5) @(posedge clk_i);
        pin <= 1'b0;
        repeat (600) @(posedge clk_i);
        wr_reg(4'h0, 8'h01);
        for (int w = 0; w < 10 && pc !== 9'h001; w++)
            step();
        // One step per edge
        for (int i = 0; i < 12; i++)
        begin
            if (i > 0)
                step();
            check(pc, (i == 11) ? HEAD : 9'(i + 1), "pc");
            check(acc, ea[i], "accum");
            check(zf, ez[i], "zero");
            check(pre, (i >= 5) ? k : 8'h00, "prescale");
            check(pop, i == 10, "pop");
        end
        $display("test program done");
        // Second cycle of the return
        step();
        check(pc, HEAD, "flush pc");
        check(acc, r, "flush accum");
        // Sleep executes
        step();
        check(pc, HEAD + 9'h001, "sleep pc");
        check({slp, osc}, 2'b10, "sleep state");
        check({ton, pdn}, 2'b10, "sleep flags");
        check(pwf, 1'b1, "pin flag");
        repeat (5) step();
        check(pc, HEAD + 9'h001, "halted pc");
        check(acc, r, "halted accum");
        rd_reg(4'h4, 8'h00);
        rd_reg(4'h1, 8'h1a);
        $display("test sleep done");
        // Wake, fetches at the next word load ff
        wr_reg(4'h0, 8'h03);
        repeat (4) step();
        check({slp, osc}, 2'b01, "wake state");
        check(acc, 8'hff, "wake accum");
        // Software clear of the pin flag, other flags kept over wake
        wr_reg(4'h1, 8'h08);
        rd_reg(4'h1, 8'h02);
        $display("test wake done");
        repeat (2) @(posedge clk_i);
        close_out();
    end
endmodule : cise_core_tb

// >>> bench/cise_prog_mem.sv
/*
 * Program memory and stack head model facing the execution core.
 * Assumes the bench loads words while the core is not running.
 */
module cise_prog_mem #(
    parameter int PC_W = 9,
    parameter logic [PC_W-1:0] RET_ADDR = 9'h040
) (
    input wire logic clk_i,
    input wire logic [PC_W-1:0] pc_i,
    output logic [11:0] instr_o,
    input wire logic stack_pop_i,
    output logic [PC_W-1:0] stack_head_o,
    input wire logic load_i,
    input wire logic [PC_W-1:0] load_addr_i,
    input wire logic [11:0] load_data_i
);
    timeunit 1ns;
    timeprecision 1ns;
    // ============================================================
    // Storage
    logic [11:0] mem [0:(1<<PC_W)-1]; // Words, unloaded ones load literal ff
    logic popped_reg = 1'b0; // Head entry consumed
    // Fill so a stray fetch changes the accumulator
    initial
    begin
        for (int i = 0; i < (1 << PC_W); i++)
            mem[i] = 12'hcff;
    end
    // Combinational fetch
    assign instr_o = mem[pc_i];
    // Consumed head no longer shows the return address
    assign stack_head_o = popped_reg ? ~RET_ADDR : RET_ADDR;
    // Loading and pop tracking
    always @(posedge clk_i)
    begin
        if (load_i)
            mem[load_addr_i] <= load_data_i;
        if (stack_pop_i)
            popped_reg <= 1'b1;
    end
endmodule : cise_prog_mem

// >>> hdl/cise_core.sv
/*
 * Execution core for a subset of an 8-bit instruction set: file OR, moves,
 * literal load, prescaler config load, no-operation, return with literal and
 * sleep. One instruction word is executed per clock while the run enable is set, except in the flush clock of a return and in sleep.
 * Assumes program memory answers pc_o combinationally on instr_i, and that an
 * outside stack presents its head on stack_head_entry_i and pops on request.
 */
`include "cise_params.svh"

module cise_core #(
    parameter int PC_W = 9,
    parameter int INSTR_W = 12
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    output logic [PC_W-1:0] pc_o,
    input wire logic [INSTR_W-1:0] instr_i,
    input wire logic [PC_W-1:0] stack_head_entry_i,
    output logic stack_pop_o,
    input wire logic pin_change_i,
    input wire logic [3:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    output logic [7:0] accum_o,
    output logic [7:0] prescale_cfg_o,
    output logic zero_flag_o,
    output logic expiry_flag_n_o,
    output logic power_off_flag_n_o,
    output logic pin_change_wake_flag_o,
    output logic sleeping_o,
    output logic osc_run_o
);

    // ============================================================
    // Elaboration checks
    generate
        if (INSTR_W != 12)
        begin : g_bad_instr
            $error("cise_core: instruction word must be 12 bits");
        end
        if (PC_W < 2 || PC_W > 16)
        begin : g_bad_pc
            $error("cise_core: program counter width out of range");
        end
    endgenerate

    // ============================================================
    // State
    cise_pkg::cise_state_t state_reg; // Execution state
    logic [PC_W-1:0] pc_reg;          // Program counter
    logic [7:0] accum_reg;            // Accumulator
    logic [7:0] prescale_cfg_reg;     // Prescaler configuration
    logic zero_reg;                   // Zero flag
    logic expiry_n_reg;               // Expiry flag, active low
    logic power_off_n_reg;            // Power-off flag, active low
    logic pin_wake_reg;               // Pin change wake flag
    logic run_reg;                    // Software run enable
    logic [7:0] wdt_reg;              // Watchdog counter
    logic [7:0] wdt_pre_reg;          // Watchdog prescaler
    logic [7:0] rdata_reg;            // Read data, one cycle
    logic pin_meta_reg;               // Synchroniser first stage
    logic pin_sync_reg;               // Synchroniser second stage

    // ============================================================
    // Decode
    cise_pkg::cise_op_t op;     // Decoded kind
    logic exec;                 // Instruction executes this cycle
    logic dest_file;            // Destination is the file register
    logic [4:0] file_addr;      // File operand
    logic [7:0] literal;        // Immediate operand
    logic [7:0] file_rd;        // Addressed file register
    logic [7:0] or_result;      // Accumulator OR file
    logic fr_we;                // File write enable
    logic [7:0] fr_wdata;       // File write data
    logic ctrl_wr;              // Control register write
    logic status_wr;            // Status register write
    logic wake_pulse;           // Software wake request

    // Classify the instruction word
    function automatic cise_pkg::cise_op_t decode(input logic [11:0] w);
        cise_pkg::cise_op_t k;
        k = cise_pkg::CISE_OP_NOP;
        if (w == `CISE_ENC_OPTION)
        begin
            k = cise_pkg::CISE_OP_OPTION;
        end
        else if (w == `CISE_ENC_SLEEP)
        begin
            k = cise_pkg::CISE_OP_SLEEP;
        end
        else if ((w & `CISE_MSK_STORE) == `CISE_ENC_STORE)
        begin
            k = cise_pkg::CISE_OP_STORE;
        end
        else if ((w & `CISE_MSK_FILEOP) == `CISE_ENC_OR)
        begin
            k = cise_pkg::CISE_OP_OR;
        end
        else if ((w & `CISE_MSK_FILEOP) == `CISE_ENC_COPY)
        begin
            k = cise_pkg::CISE_OP_COPY;
        end
        else if ((w & `CISE_MSK_LIT) == `CISE_ENC_RET_LIT)
        begin
            k = cise_pkg::CISE_OP_RET_LIT;
        end
        else if ((w & `CISE_MSK_LIT) == `CISE_ENC_LOAD_LIT)
        begin
            k = cise_pkg::CISE_OP_LOAD_LIT;
        end
        return k;
    endfunction : decode

    assign op = decode(instr_i);
    assign exec = run_reg && (state_reg == cise_pkg::CISE_ST_RUN);
    assign dest_file = instr_i[`CISE_DEST_BIT];
    assign file_addr = instr_i[4:0];
    assign literal = instr_i[7:0];
    assign or_result = accum_reg | file_rd;
    assign ctrl_wr = wr_i && (addr_i == `CISE_OFS_CTRL);
    assign status_wr = wr_i && (addr_i == `CISE_OFS_STATUS);
    assign wake_pulse = ctrl_wr && wdata_i[`CISE_CTRL_WAKE];

    // ============================================================
    // File register writes
    always_comb
    begin
        fr_we = 1'b0;
        fr_wdata = accum_reg;
        if (exec && op == cise_pkg::CISE_OP_OR && dest_file)
        begin
            fr_we = 1'b1;
            fr_wdata = or_result;
        end
        else if (exec && op == cise_pkg::CISE_OP_STORE)
        begin
            fr_we = 1'b1;
            fr_wdata = accum_reg;
        end
        else if (exec && op == cise_pkg::CISE_OP_COPY && dest_file)
        begin
            fr_we = 1'b1;
            fr_wdata = file_rd;
        end
    end

    cise_filereg #(
        .ADDR_W(5),
        .DATA_W(8)
    ) u_filereg (
        .clk_i(clk_i),
        .rd_addr_i(file_addr),
        .rd_data_o(file_rd),
        .we_i(fr_we),
        .wr_addr_i(file_addr),
        .wr_data_i(fr_wdata)
    );

    // ============================================================
    // Execution state and program counter
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            state_reg <= cise_pkg::CISE_ST_RUN;
            pc_reg <= '0;
        end
        else
        begin
            case (state_reg)
                cise_pkg::CISE_ST_RUN:
                begin
                    if (exec)
                    begin
                        if (op == cise_pkg::CISE_OP_RET_LIT)
                        begin
                            pc_reg <= stack_head_entry_i;
                            state_reg <= cise_pkg::CISE_ST_FLUSH;
                        end
                        else if (op == cise_pkg::CISE_OP_SLEEP)
                        begin
                            pc_reg <= pc_reg + PC_W'(1);
                            state_reg <= cise_pkg::CISE_ST_SLEEP;
                        end
                        else
                        begin
                            pc_reg <= pc_reg + PC_W'(1);
                        end
                    end
                end
                cise_pkg::CISE_ST_FLUSH:
                begin
                    state_reg <= cise_pkg::CISE_ST_RUN;
                end
                cise_pkg::CISE_ST_SLEEP:
                begin
                    if (wake_pulse)
                    begin
                        state_reg <= cise_pkg::CISE_ST_RUN;
                    end
                end
                default:
                begin
                    state_reg <= cise_pkg::CISE_ST_RUN;
                end
            endcase
        end
    end

    // ============================================================
    // Accumulator and zero flag
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            accum_reg <= `CISE_RST_BYTE;
            zero_reg <= 1'b0;
        end
        else if (exec)
        begin
            case (op)
                cise_pkg::CISE_OP_OR:
                begin
                    if (!dest_file)
                    begin
                        accum_reg <= or_result;
                    end
                    zero_reg <= (or_result == 8'h00);
                end
                cise_pkg::CISE_OP_COPY:
                begin
                    if (!dest_file)
                    begin
                        accum_reg <= file_rd;
                    end
                    zero_reg <= (file_rd == 8'h00);
                end
                cise_pkg::CISE_OP_LOAD_LIT:
                begin
                    accum_reg <= literal;
                end
                cise_pkg::CISE_OP_RET_LIT:
                begin
                    accum_reg <= literal;
                end
                default:
                begin
                    accum_reg <= accum_reg;
                end
            endcase
        end
    end

    // ============================================================
    // Prescaler configuration
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            prescale_cfg_reg <= `CISE_RST_BYTE;
        end
        else if (exec && op == cise_pkg::CISE_OP_OPTION)
        begin
            prescale_cfg_reg <= accum_reg;
        end
    end

    // ============================================================
    // Watchdog counter and prescaler, run while awake
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            wdt_reg <= `CISE_RST_BYTE;
            wdt_pre_reg <= `CISE_RST_BYTE;
        end
        else if (exec && op == cise_pkg::CISE_OP_SLEEP)
        begin
            wdt_reg <= 8'h00;
            wdt_pre_reg <= 8'h00;
        end
        else if (state_reg != cise_pkg::CISE_ST_SLEEP)
        begin
            wdt_pre_reg <= wdt_pre_reg + 8'h01;
            if (wdt_pre_reg == 8'hff)
            begin
                wdt_reg <= wdt_reg + 8'h01;
            end
        end
    end

    // ============================================================
    // Power flags, active low
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            expiry_n_reg <= `CISE_RST_FLAG_N;
            power_off_n_reg <= `CISE_RST_FLAG_N;
        end
        else if (exec && op == cise_pkg::CISE_OP_SLEEP)
        begin
            expiry_n_reg <= 1'b1;
            power_off_n_reg <= 1'b0;
        end
    end

    // ============================================================
    // Pin change wake flag, set wins over clear
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            pin_meta_reg <= 1'b0;
            pin_sync_reg <= 1'b0;
            pin_wake_reg <= 1'b0;
        end
        else
        begin
            pin_meta_reg <= pin_change_i;
            pin_sync_reg <= pin_meta_reg;
            // Sleep never touches this flag
            if (pin_sync_reg)
            begin
                pin_wake_reg <= 1'b1;
            end
            else if (status_wr && wdata_i[`CISE_ST_PIN_WAKE])
            begin
                pin_wake_reg <= 1'b0;
            end
        end
    end

    // ============================================================
    // Register bus: control write, one-cycle read data
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            run_reg <= 1'b0;
        end
        else if (ctrl_wr)
        begin
            run_reg <= wdata_i[`CISE_CTRL_RUN];
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            rdata_reg <= 8'h00;
        end
        else if (!rd_i)
        begin
            rdata_reg <= 8'h00;
        end
        else if (addr_i == `CISE_OFS_CTRL)
        begin
            rdata_reg <= {7'h00, run_reg};
        end
        else if (addr_i == `CISE_OFS_STATUS)
        begin
            rdata_reg <= {3'h0, sleeping_o, pin_wake_reg, power_off_n_reg,
                          expiry_n_reg, zero_reg};
        end
        else if (addr_i == `CISE_OFS_ACCUM)
        begin
            rdata_reg <= accum_reg;
        end
        else if (addr_i == `CISE_OFS_PRESCALE)
        begin
            rdata_reg <= prescale_cfg_reg;
        end
        else if (addr_i == `CISE_OFS_WDT)
        begin
            rdata_reg <= wdt_reg;
        end
        else if (addr_i == `CISE_OFS_PC)
        begin
            rdata_reg <= 8'(pc_reg);
        end
        else
        begin
            rdata_reg <= 8'h00; // Unmapped
        end
    end

    // ============================================================
    // Outputs
    assign pc_o = pc_reg;
    assign stack_pop_o = exec && (op == cise_pkg::CISE_OP_RET_LIT);
    assign rdata_o = rdata_reg;
    assign accum_o = accum_reg;
    assign prescale_cfg_o = prescale_cfg_reg;
    assign zero_flag_o = zero_reg;
    assign expiry_flag_n_o = expiry_n_reg;
    assign power_off_flag_n_o = power_off_n_reg;
    assign pin_change_wake_flag_o = pin_wake_reg;
    assign sleeping_o = (state_reg == cise_pkg::CISE_ST_SLEEP);
    assign osc_run_o = !sleeping_o;

    // ============================================================
    // Assertions
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    sequence s_ret_issue;
        exec && op == cise_pkg::CISE_OP_RET_LIT;
    endsequence

    sequence s_ret_finish;
        state_reg == cise_pkg::CISE_ST_FLUSH && !exec ##1 state_reg == cise_pkg::CISE_ST_RUN;
    endsequence

    a_or_accum: assert property (
        exec && op == cise_pkg::CISE_OP_OR && !dest_file
        |=> accum_reg == $past(or_result) && zero_reg == ($past(or_result) == 8'h00))
        else $error("OR to accumulator wrong");

    a_store_file: assert property (
        exec && op == cise_pkg::CISE_OP_STORE
        |-> fr_we && fr_wdata == accum_reg ##1 $stable(zero_reg) && $stable(accum_reg))
        else $error("Store to file wrong");

    a_copy_zero: assert property (
        exec && op == cise_pkg::CISE_OP_COPY
        |=> zero_reg == ($past(file_rd) == 8'h00))
        else $error("Copy zero flag wrong");

    a_literal_load: assert property (
        exec && op == cise_pkg::CISE_OP_LOAD_LIT
        |=> accum_reg == $past(literal) && $stable(zero_reg))
        else $error("Literal load wrong");

    a_prescale_load: assert property (
        exec && op == cise_pkg::CISE_OP_OPTION
        |=> prescale_cfg_reg == $past(accum_reg) && $stable(zero_reg))
        else $error("Prescaler config load wrong");

    a_return_pc: assert property (
        s_ret_issue |=> pc_reg == $past(stack_head_entry_i) && accum_reg == $past(literal))
        else $error("Return target wrong");

    a_return_cycles: assert property (
        s_ret_issue |=> s_ret_finish)
        else $error("Return not two cycles");

    a_sleep_wdt: assert property (
        exec && op == cise_pkg::CISE_OP_SLEEP |=> wdt_reg == 8'h00 && wdt_pre_reg == 8'h00)
        else $error("Watchdog not cleared on sleep");

    a_sleep_flags: assert property (
        exec && op == cise_pkg::CISE_OP_SLEEP |=> expiry_n_reg && !power_off_n_reg)
        else $error("Power flags wrong after sleep");

    a_sleep_pin_flag: assert property (
        exec && op == cise_pkg::CISE_OP_SLEEP && !pin_sync_reg && !status_wr
        |=> $stable(pin_wake_reg))
        else $error("Pin wake flag changed by sleep");

    a_sleep_halt: assert property (
        exec && op == cise_pkg::CISE_OP_SLEEP ##1 !wake_pulse [*2]
        |-> sleeping_o && !osc_run_o && $stable(pc_reg) && !exec)
        else $error("Sleep did not halt");

    a_nop_advance: assert property (
        exec && op == cise_pkg::CISE_OP_NOP
        |=> pc_reg == $past(pc_reg) + PC_W'(1) && $stable(accum_reg) && $stable(zero_reg))
        else $error("No-operation changed state");

endmodule : cise_core

// >>> hdl/cise_filereg.sv
/*
 * File register array: one combinational read port, one clocked write port.
 * Assumes write address and data are stable on the clock edge.
 */
module cise_filereg #(
    parameter int ADDR_W = 5,
    parameter int DATA_W = 8
) (
    input wire logic clk_i,
    input wire logic [ADDR_W-1:0] rd_addr_i,
    output logic [DATA_W-1:0] rd_data_o,
    input wire logic we_i,
    input wire logic [ADDR_W-1:0] wr_addr_i,
    input wire logic [DATA_W-1:0] wr_data_i
);

    // ============================================================
    // Storage
    logic [DATA_W-1:0] mem_reg [0:(1<<ADDR_W)-1]; // Data, no reset

    generate
        if (ADDR_W < 1 || DATA_W < 1)
        begin : g_bad
            $error("cise_filereg: widths must be positive");
        end
    endgenerate

    // Write port
    always_ff @(posedge clk_i)
    begin
        if (we_i)
        begin
            mem_reg[wr_addr_i] <= wr_data_i;
        end
    end

    // Read port, combinational
    assign rd_data_o = mem_reg[rd_addr_i];

endmodule : cise_filereg

// >>> hdl/cise_params.svh
/*
 * Constants of the instruction subset execution core: register offsets,
 * field positions, reset values and instruction encodings.
 * Assumes it is included by its bare name from the design files only.
 */
// Overview of operation
// - OR accumulator with file, pick destination, update zero
// - Store accumulator to file register, flags untouched
// - Copy file to destination, zero flag updated
// - Load literal into accumulator, flags untouched
// - Accumulator into prescaler config, flags untouched
// - Return loads literal and pc from stack head
// - Return takes two instruction cycles
// - Sleep clears watchdog counter and prescaler
// - Sleep sets expiry flag, clears power-off flag
// - Sleep leaves pin change wake flag alone
// - Sleep stops oscillator and halts execution
`ifndef CISE_PARAMS_SVH
`define CISE_PARAMS_SVH

// ============================================================
// Register offsets
`define CISE_OFS_CTRL 4'h0
`define CISE_OFS_STATUS 4'h1
`define CISE_OFS_ACCUM 4'h2
`define CISE_OFS_PRESCALE 4'h3
`define CISE_OFS_WDT 4'h4
`define CISE_OFS_PC 4'h5

// ============================================================
// Field positions
`define CISE_CTRL_RUN 0
`define CISE_CTRL_WAKE 1
`define CISE_ST_ZERO 0
`define CISE_ST_EXPIRY_N 1
`define CISE_ST_POWER_OFF_N 2
`define CISE_ST_PIN_WAKE 3
`define CISE_ST_SLEEPING 4

// ============================================================
// Reset values
`define CISE_RST_BYTE 8'h00
`define CISE_RST_FLAG_N 1'b1

// ============================================================
// Instruction encodings, 12-bit words
`define CISE_ENC_NOP 12'h000
`define CISE_ENC_OPTION 12'h002
`define CISE_ENC_SLEEP 12'h003
`define CISE_MSK_STORE 12'hfe0
`define CISE_ENC_STORE 12'h020
`define CISE_MSK_FILEOP 12'hfc0
`define CISE_ENC_OR 12'h100
`define CISE_ENC_COPY 12'h200
`define CISE_MSK_LIT 12'hf00
`define CISE_ENC_RET_LIT 12'h800
`define CISE_ENC_LOAD_LIT 12'hc00
`define CISE_DEST_BIT 5

`endif

// >>> hdl/cise_pkg.sv
/*
 * Types of the instruction subset execution core.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package cise_pkg;

    // ============================================================
    // Core execution state
    typedef enum logic [1:0]
    {
        CISE_ST_RUN = 2'b00,   // Executing one word per clock
        CISE_ST_FLUSH = 2'b01, // Second cycle of a return
        CISE_ST_SLEEP = 2'b10  // Oscillator stopped
    } cise_state_t;

    // ============================================================
    // Decoded instruction kind
    typedef enum logic [2:0]
    {
        CISE_OP_NOP = 3'b000,
        CISE_OP_OR = 3'b001,
        CISE_OP_STORE = 3'b010,
        CISE_OP_COPY = 3'b011,
        CISE_OP_LOAD_LIT = 3'b100,
        CISE_OP_OPTION = 3'b101,
        CISE_OP_RET_LIT = 3'b110,
        CISE_OP_SLEEP = 3'b111
    } cise_op_t;

endpackage : cise_pkg
